// File: hw/pdr_channel_pair.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Ten registers at fixed offsets; pointers, counters, status reset to zero
// R2 - Receive address register holds the next receive transfer location
// R3 - Receive count low 16 bits give transfers left; upper bits read zero
// R4 - Transmit address register holds where the next outgoing item is fetched
// R5 - Transmit count in low 16 bits; zero count stops transmit transfers
// R6 - Next receive address names the buffer used after the current fills
// R7 - Next receive count gives the size of the following receive buffer
// R8 - Next transmit address names the buffer sent after the current empties
// R9 - Next transmit count gives the size of the following transmit buffer
// R10 - Transfer control register is write-only, reads carry no value
// R11 - Read-only status shows receive and transmit enables, zero after reset
// R12 - Each transfer advances address by 1, 2 or 4 and decrements count
// R13 - Count at zero loads next address and count, then next count clears
// R14 - End flag at zero count, chain flag at both zero; count writes clear
// R15 - Enable bits 0 and 8, disable bits 1 and 9; disable wins

// ---------------------------------------------------------------------
// Receive data FIFO
// ---------------------------------------------------------------------
module pdr_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   import pdr_pkg::*;
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 fill;
      logic                        room;
      logic                        avail;
   } pdr_fifo_st_t;

   pdr_fifo_st_t st;
   pdr_fifo_st_t next_st;
   logic         push;
   logic         pop;

   function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
      // Explicit wrap keeps non power of two depths legal
      if (p == AW'(DEPTH - 1)) begin
         return '0;
      end
      return p + AW'(1);
   endfunction : wrap_inc

   always_comb begin
      next_st = st;
      push    = in_valid && st.room;
      pop     = out_ready && st.avail;
      if (push) begin
         next_st.mem[st.wr] = in_data;
         next_st.wr         = wrap_inc(st.wr);
      end
      if (pop) begin
         next_st.rd = wrap_inc(st.rd);
      end
      if (push && !pop) begin
         next_st.fill = st.fill + (AW+1)'(1);
      end else if (pop && !push) begin
         next_st.fill = st.fill - (AW+1)'(1);
      end
      next_st.room  = (next_st.fill != (AW+1)'(DEPTH));
      next_st.avail = (next_st.fill != '0);
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st      <= '0;
         st.room <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign in_ready  = st.room;
   assign out_valid = st.avail;
   assign out_data  = st.mem[st.rd];

endmodule : pdr_fifo

// ---------------------------------------------------------------------
// Channel pair with register window
// ---------------------------------------------------------------------
module pdr_channel_pair #(
   parameter int unsigned FIFO_DEPTH = pdr_pkg::FIFO_DEPTH
) (
   input  wire logic                          sys_clk,
   input  wire logic                          resetn,
   input  wire logic [pdr_pkg::PDR_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [pdr_pkg::PDR_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire pdr_pkg::pdr_unit_t            unit_size,
   input  wire logic                          rx_valid,
   input  wire logic [31:0]                   rx_data,
   output logic                               rx_ready,
   input  wire logic                          tx_request,
   output logic                               tx_valid,
   output logic [31:0]                        tx_data,
   output pdr_pkg::pdr_mem_req_t              mem_req,
   input  wire logic                          mem_ack,
   input  wire logic [31:0]                   mem_rdata,
   output pdr_pkg::pdr_flags_t                flags
);
   import pdr_pkg::*;

   typedef struct packed {
      logic                  aw_held;
      logic [PDR_ADDR_W-1:0] aw_addr;
      logic                  w_held;
      logic [31:0]           w_data;
      logic [3:0]            w_strb;
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
      logic [31:0]           receive_address_field;
      logic [CNT_W-1:0]      receive_count_field;
      logic [31:0]           transmit_address_field;
      logic [CNT_W-1:0]      transmit_count_field;
      logic [31:0]           receive_next_address_field;
      logic [CNT_W-1:0]      receive_next_count_field;
      logic [31:0]           transmit_next_address_field;
      logic [CNT_W-1:0]      transmit_next_count_field;
      logic                  receive_request_enable;
      logic                  transmit_request_enable;
      logic                  tx_pend;
      pdr_fsm_t              fsm;
      pdr_mem_req_t          mem;
      logic                  tx_valid;
      logic [31:0]           tx_data;
      pdr_flags_t            flags;
   } pdr_st_t;

   pdr_st_t     st;
   pdr_st_t     next_st;
   logic        wr_go;
   logic [31:0] wr_val;
   logic [31:0] step;
   logic        drain_ok;
   logic        fifo_valid;
   logic [31:0] fifo_data;
   logic        fifo_pop;
   logic        tx_go;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [31:0] unit_step(input pdr_unit_t u);
      case (u)
         PDR_UNIT_BYTE: return STEP_BYTE;
         PDR_UNIT_HALF: return STEP_HALF;
         default:       return STEP_WORD;
      endcase
   endfunction : unit_step

   // -----------------------------------------------------------------
   // Receive FIFO
   // -----------------------------------------------------------------
   // Back-pressure reaches the peripheral when memory stalls or requests are off
   pdr_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .in_valid  (rx_valid),
      .in_data   (rx_data),
      .in_ready  (rx_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (drain_ok)
   );

   assign wr_go    = st.aw_held && st.w_held && !st.bvalid;
   assign wr_val   = merge(RST_WORD, st.w_data, st.w_strb);
   assign step     = unit_step(st.mem.unit);
   assign drain_ok = (st.fsm == PDR_IDLE) && st.receive_request_enable && (st.receive_count_field != '0);
   assign fifo_pop = drain_ok && fifo_valid;
   // R5
   assign tx_go    = st.tx_pend && st.transmit_request_enable && (st.transmit_count_field != '0);

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      next_st          = st;
      next_st.tx_valid = 1'b0;
      if (s_axi_awvalid && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end

      // Receive has priority over transmit
      case (st.fsm)
         PDR_IDLE: begin
            if (fifo_pop) begin
               next_st.mem = '{valid: 1'b1, write: 1'b1, unit: unit_size,
                               addr: st.receive_address_field, wdata: fifo_data};
               next_st.fsm = PDR_RXW;
            end else if (tx_go) begin
               next_st.mem     = '{valid: 1'b1, write: 1'b0, unit: unit_size,
                                   addr: st.transmit_address_field, wdata: RST_WORD};
               next_st.fsm     = PDR_TXR;
               next_st.tx_pend = 1'b0;
            end
         end
         PDR_RXW: begin
            if (mem_ack) begin
               next_st.mem.valid             = 1'b0;
               next_st.fsm                   = PDR_IDLE;
               next_st.receive_address_field = st.receive_address_field + step; // R12
               if (st.receive_count_field != '0) begin
                  next_st.receive_count_field = st.receive_count_field - CNT_W'(1); // R12
               end
            end
         end
         PDR_TXR: begin
            if (mem_ack) begin
               next_st.mem.valid              = 1'b0;
               next_st.fsm                    = PDR_IDLE;
               next_st.tx_valid               = 1'b1;
               next_st.tx_data                = mem_rdata;
               next_st.transmit_address_field = st.transmit_address_field + step; // R12
               if (st.transmit_count_field != '0) begin
                  next_st.transmit_count_field = st.transmit_count_field - CNT_W'(1); // R12
               end
            end
         end
         default: begin
            next_st.fsm       = PDR_IDLE;
            next_st.mem.valid = 1'b0;
         end
      endcase
      // A request in the cycle of its launch is kept
      if (tx_request) begin
         next_st.tx_pend = 1'b1;
      end

      // Software write wins over the transfer update of the same register; a chain load below still overrides it
      if (wr_go) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = RESP_OKAY;
         case (st.aw_addr)
            OFF_RX_ADDR:  next_st.receive_address_field = merge(st.receive_address_field, st.w_data, st.w_strb); // R2
            OFF_RX_CNT:   next_st.receive_count_field =
                             merge({16'h0, st.receive_count_field}, st.w_data, st.w_strb)[CNT_W-1:0]; // R3
            OFF_TX_ADDR:  next_st.transmit_address_field = merge(st.transmit_address_field, st.w_data, st.w_strb); // R4
            OFF_TX_CNT:   next_st.transmit_count_field =
                             merge({16'h0, st.transmit_count_field}, st.w_data, st.w_strb)[CNT_W-1:0]; // R5
            OFF_RXN_ADDR: next_st.receive_next_address_field =
                             merge(st.receive_next_address_field, st.w_data, st.w_strb); // R6
            OFF_RXN_CNT:  next_st.receive_next_count_field =
                             merge({16'h0, st.receive_next_count_field}, st.w_data, st.w_strb)[CNT_W-1:0]; // R7
            OFF_TXN_ADDR: next_st.transmit_next_address_field =
                             merge(st.transmit_next_address_field, st.w_data, st.w_strb); // R8
            OFF_TXN_CNT:  next_st.transmit_next_count_field =
                             merge({16'h0, st.transmit_next_count_field}, st.w_data, st.w_strb)[CNT_W-1:0]; // R9
            OFF_CTRL: begin
               // R15
               if (wr_val[BIT_RX_EN]) begin
                  next_st.receive_request_enable = 1'b1;
               end
               if (wr_val[BIT_RX_DIS]) begin
                  next_st.receive_request_enable = 1'b0;
               end
               if (wr_val[BIT_TX_EN]) begin
                  next_st.transmit_request_enable = 1'b1;
               end
               if (wr_val[BIT_TX_DIS]) begin
                  next_st.transmit_request_enable = 1'b0;
               end
            end
            OFF_STATE: next_st.bresp = RESP_OKAY;
            default:   next_st.bresp = RESP_SLVERR;
         endcase
      end

      // Buffer chaining, also after a software write of a zero count
      if (next_st.receive_count_field == '0 && next_st.receive_next_count_field != '0) begin
         next_st.receive_count_field      = next_st.receive_next_count_field; // R13
         next_st.receive_address_field    = next_st.receive_next_address_field; // R13
         next_st.receive_next_count_field = '0; // R13
      end
      if (next_st.transmit_count_field == '0 && next_st.transmit_next_count_field != '0) begin
         next_st.transmit_count_field      = next_st.transmit_next_count_field; // R13
         next_st.transmit_address_field    = next_st.transmit_next_address_field; // R13
         next_st.transmit_next_count_field = '0; // R13
      end

      if (s_axi_arvalid && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = RESP_OKAY;
         case (s_axi_araddr)
            OFF_RX_ADDR:  next_st.rdata = st.receive_address_field; // R2
            OFF_RX_CNT:   next_st.rdata = {16'h0, st.receive_count_field}; // R3
            OFF_TX_ADDR:  next_st.rdata = st.transmit_address_field; // R4
            OFF_TX_CNT:   next_st.rdata = {16'h0, st.transmit_count_field}; // R5
            OFF_RXN_ADDR: next_st.rdata = st.receive_next_address_field; // R6
            OFF_RXN_CNT:  next_st.rdata = {16'h0, st.receive_next_count_field}; // R7
            OFF_TXN_ADDR: next_st.rdata = st.transmit_next_address_field; // R8
            OFF_TXN_CNT:  next_st.rdata = {16'h0, st.transmit_next_count_field}; // R9
            OFF_CTRL:     next_st.rdata = RST_WORD; // R10
            OFF_STATE:    next_st.rdata = {23'h0, st.transmit_request_enable, 7'h0,
                                           st.receive_request_enable}; // R11
            default: begin
               next_st.rdata = RST_WORD;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end

      next_st.awready = !next_st.aw_held && !next_st.bvalid;
      next_st.wready  = !next_st.w_held && !next_st.bvalid;
      next_st.arready = !next_st.rvalid;

      // Flags follow the counts, so any count write that loads nonzero clears them
      next_st.flags.receive_buffer_end_flag   = (next_st.receive_count_field == '0); // R14
      next_st.flags.transmit_buffer_end_flag  = (next_st.transmit_count_field == '0); // R14
      next_st.flags.receive_chain_full_flag   = (next_st.receive_count_field == '0) &&
                                                (next_st.receive_next_count_field == '0); // R14
      next_st.flags.transmit_chain_empty_flag = (next_st.transmit_count_field == '0) &&
                                                (next_st.transmit_next_count_field == '0); // R14
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st       <= '0; // R1
         st.fsm   <= PDR_IDLE;
         st.flags <= RST_FLAGS;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign tx_valid      = st.tx_valid;
   assign tx_data       = st.tx_data;
   assign mem_req       = st.mem;
   assign flags         = st.flags;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence rd_take(logic [PDR_ADDR_W-1:0] a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   sequence rx_done;
      st.fsm == PDR_RXW && mem_ack && !wr_go && st.receive_count_field > CNT_W'(1);
   endsequence

   rx_addr_read_a: assert property (rd_take(OFF_RX_ADDR) |=> s_axi_rvalid && // R2
      s_axi_rdata == $past(st.receive_address_field)) else $error("receive address readback wrong");
   count_read_a: assert property (rd_take(OFF_RX_CNT) |=> s_axi_rdata[31:16] == 16'h0 && // R3
      s_axi_rdata[15:0] == $past(st.receive_count_field)) else $error("receive count readback wrong");
   ctrl_read_a: assert property (rd_take(OFF_CTRL) |=> s_axi_rdata == 32'h0 && // R10
      s_axi_rresp == RESP_OKAY) else $error("control read not zero");
   status_read_a: assert property (rd_take(OFF_STATE) |=> s_axi_rdata == {23'h0, // R11
      $past(st.transmit_request_enable), 7'h0, $past(st.receive_request_enable)}) else $error("status wrong");
   rx_step_a: assert property (rx_done |=> st.receive_address_field == // R12
      $past(st.receive_address_field) + $past(step)) else $error("address step wrong");
   rx_count_a: assert property (rx_done |=> st.receive_count_field == // R12
      $past(st.receive_count_field) - CNT_W'(1)) else $error("count not decremented");
   chain_load_a: assert property (st.fsm == PDR_RXW && mem_ack && !wr_go && // R13
      st.receive_count_field == CNT_W'(1) && st.receive_next_count_field != '0
      |=> st.receive_count_field == $past(st.receive_next_count_field) &&
      st.receive_next_count_field == '0) else $error("chain load wrong");
   tx_stop_a: assert property (st.fsm == PDR_IDLE && st.transmit_count_field == '0 // R5
      |=> st.fsm != PDR_TXR) else $error("transmit with zero count");
   end_flag_a: assert property (flags.receive_buffer_end_flag == (st.receive_count_field == '0) && // R14
      flags.transmit_chain_empty_flag == (st.transmit_count_field == '0 &&
      st.transmit_next_count_field == '0)) else $error("flag mismatch");
   disable_wins_a: assert property (wr_go && st.aw_addr == OFF_CTRL && wr_val[BIT_RX_DIS] // R15
      |=> !st.receive_request_enable [*2]) else $error("disable did not win");
   write_resp_a: assert property (wr_go |=> s_axi_bvalid && !s_axi_awready) else $error("no write response");

endmodule : pdr_channel_pair

// File: hw/pdr_pkg.sv
package pdr_pkg;
   // -----------------------------------------------------------------
   // Register window
   // -----------------------------------------------------------------
   localparam int unsigned PDR_ADDR_W  = 12;
   localparam int unsigned CNT_W       = 16;
   localparam int unsigned FIFO_DEPTH  = 16;
   localparam int unsigned DATA_W      = 32;

   localparam logic [PDR_ADDR_W-1:0] OFF_RX_ADDR  = 12'h100;
   localparam logic [PDR_ADDR_W-1:0] OFF_RX_CNT   = 12'h104;
   localparam logic [PDR_ADDR_W-1:0] OFF_TX_ADDR  = 12'h108;
   localparam logic [PDR_ADDR_W-1:0] OFF_TX_CNT   = 12'h10c;
   localparam logic [PDR_ADDR_W-1:0] OFF_RXN_ADDR = 12'h110;
   localparam logic [PDR_ADDR_W-1:0] OFF_RXN_CNT  = 12'h114;
   localparam logic [PDR_ADDR_W-1:0] OFF_TXN_ADDR = 12'h118;
   localparam logic [PDR_ADDR_W-1:0] OFF_TXN_CNT  = 12'h11c;
   localparam logic [PDR_ADDR_W-1:0] OFF_CTRL     = 12'h120;
   localparam logic [PDR_ADDR_W-1:0] OFF_STATE    = 12'h124;

   localparam int unsigned BIT_RX_EN  = 0;
   localparam int unsigned BIT_RX_DIS = 1;
   localparam int unsigned BIT_TX_EN  = 8;
   localparam int unsigned BIT_TX_DIS = 9;

   localparam logic [31:0] RST_WORD   = 32'h0;
   localparam logic [3:0]  RST_FLAGS  = 4'hf;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   localparam logic [31:0] STEP_BYTE = 32'h1;
   localparam logic [31:0] STEP_HALF = 32'h2;
   localparam logic [31:0] STEP_WORD = 32'h4;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      PDR_UNIT_BYTE = 2'h0,
      PDR_UNIT_HALF = 2'h1,
      PDR_UNIT_WORD = 2'h2
   } pdr_unit_t;

   typedef enum logic [2:0] {
      PDR_IDLE = 3'h1,
      PDR_RXW  = 3'h2,
      PDR_TXR  = 3'h4
   } pdr_fsm_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      pdr_unit_t   unit;
      logic [31:0] addr;
      logic [31:0] wdata;
   } pdr_mem_req_t;

   typedef struct packed {
      logic receive_buffer_end_flag;
      logic transmit_buffer_end_flag;
      logic receive_chain_full_flag;
      logic transmit_chain_empty_flag;
   } pdr_flags_t;

endpackage : pdr_pkg

// File: bench/pdr_mem_model.sv
`timescale 1ns/10ps
module pdr_mem_model (
   input  wire logic                  sys_clk,
   input  wire pdr_pkg::pdr_mem_req_t mem_req,
   output logic                       mem_ack,
   output logic [31:0]                mem_rdata
);
   import pdr_pkg::*;
   int n = 0;
   initial mem_ack = 1'b0;
   initial mem_rdata = 32'h0;
   // Slow answer; idle data keeps toggling so stale words never look right
   always @(posedge sys_clk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      n = (mem_req.valid === 1'b1 && !mem_ack) ? n + 1 : 0;
      if (n > 2) begin
         mem_ack <= 1'b1;
         mem_rdata <= ~mem_req.addr;
      end
   end
endmodule : pdr_mem_model

// File: bench/tb_pdr_channel_pair.sv
`timescale 1ns/10ps
module tb_pdr_channel_pair;
   import pdr_pkg::*;
   logic         sys_clk, resetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic         rxv = 1'b0, txq = 1'b0, ack, awr, wr_r, bv, arr, rv, rxr, txv, h;
   logic [11:0]  awa = 12'h0, ara = 12'h0;
   logic [31:0]  wd = 32'h0, rxd = 32'h0, mrd, rdat, txd, a, b, d, s;
   logic [1:0]   br, rr;
   pdr_mem_req_t mq;
   pdr_flags_t   fl;
   pdr_unit_t    un = PDR_UNIT_WORD;
   int           errors = 0, compares = 0, seed = 37906, cyc = 0, ntx = 0;
   logic [31:0]  eq[$], dq[$];
   pdr_channel_pair #(.FIFO_DEPTH(16)) pdr_channel_pair_inst (.sys_clk, .resetn, .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .unit_size(un), .rx_valid(rxv), .rx_data(rxd), .rx_ready(rxr),
      .tx_request(txq), .tx_valid(txv), .tx_data(txd), .mem_req(mq), .mem_ack(ack), .mem_rdata(mrd),
      .flags(fl));
   pdr_mem_model pdr_mem_model_inst (.sys_clk, .mem_req(mq), .mem_ack(ack), .mem_rdata(mrd));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] sn, input logic [31:0] ex);
      compares++;
      if (sn !== ex) begin
         errors++;
         $display("[FAIL] t=%0t seen %h exp %h", $time, sn, ex);
      end
   endtask : chk
   task automatic stop_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // Ready is judged just before the edge, so release lands on the taking edge
   task automatic wr(input logic [11:0] ad, input logic [31:0] v, input logic [1:0] er);
      logic ha, hw, hb;
      awa <= ad;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(negedge sys_clk);
         ha = awv && awr;
         hw = wv && wr_r;
         hb = bv === 1'b1;
         if (hb) chk(32'(br), 32'(er));
         @(posedge sys_clk);
         if (ha) awv <= 1'b0;
         if (hw) wv <= 1'b0;
      end while (!hb);
   endtask : wr
   task automatic rd(input logic [11:0] ad, input logic [31:0] ex, input logic [1:0] er);
      logic ha, hr;
      ara <= ad;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(negedge sys_clk);
         ha = arv && arr;
         hr = rv === 1'b1;
         if (hr) chk(rdat, ex);
         if (hr) chk(32'(rr), 32'(er));
         @(posedge sys_clk);
         if (ha) arv <= 1'b0;
      end while (!hr);
   endtask : rd
   always @(negedge sys_clk) begin
      if (mq.valid === 1'b1 && ack && mq.write) begin
         chk(mq.addr, eq.pop_front());
         chk(mq.wdata, dq.pop_front());
      end
      if (txv === 1'b1) begin
         ntx++;
         chk(txd, ~a);
      end
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      wr(OFF_STATE, 32'hffffffff, RESP_OKAY);
      for (int i = 0; i < 10; i++) rd(12'h100 + 12'(4 * i), 32'h0, RESP_OKAY);
      rd(12'h200, 32'h0, RESP_SLVERR);
      wr(12'h200, 32'h1, RESP_SLVERR);
      for (int i = 0; i < 8; i++) begin
         d = $random(seed) | 32'h1;
         wr(12'h100 + 12'(4 * i), d, RESP_OKAY);
         rd(12'h100 + 12'(4 * i), (i % 2) ? d & 32'hffff : d, RESP_OKAY);
      end
      wr(OFF_CTRL, 32'h303, RESP_OKAY);
      rd(OFF_STATE, 32'h0, RESP_OKAY);
      wr(OFF_CTRL, 32'h101, RESP_OKAY);
      rd(OFF_STATE, 32'h101, RESP_OKAY);
      $display("test registers done");
      un <= pdr_unit_t'($unsigned($random(seed)) % 3);
      a = $random(seed);
      b = $random(seed);
      wr(OFF_RX_CNT, 32'h2, RESP_OKAY);
      wr(OFF_RXN_ADDR, b, RESP_OKAY);
      wr(OFF_RXN_CNT, 32'h1, RESP_OKAY);
      wr(OFF_RX_ADDR, a, RESP_OKAY);
      s = 32'h1 << un;
      eq = '{a, a + s, b};
      rxv <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         d = $random(seed);
         dq.push_back(d);
         rxd <= d;
         do begin
            @(negedge sys_clk);
            h = rxr;
            @(posedge sys_clk);
         end while (h !== 1'b1);
      end
      rxv <= 1'b0;
      for (int t = 0; t < 300 && eq.size() > 0; t++) @(posedge sys_clk);
      chk(eq.size(), 0);
      rd(OFF_RX_ADDR, b + s, RESP_OKAY);
      rd(OFF_RXN_CNT, 32'h0, RESP_OKAY);
      chk(32'(fl), 32'ha);
      $display("test receive done");
      wr(OFF_TXN_CNT, 32'h0, RESP_OKAY);
      a = $random(seed);
      wr(OFF_TX_ADDR, a, RESP_OKAY);
      wr(OFF_TX_CNT, 32'h1, RESP_OKAY);
      for (int k = 0; k < 2; k++) begin
         txq <= 1'b1;
         @(posedge sys_clk);
         txq <= 1'b0;
         repeat (40) @(posedge sys_clk);
         chk(ntx, 1);
      end
      rd(OFF_TX_ADDR, a + s, RESP_OKAY);
      chk(32'(fl), 32'hf);
      $display("test transmit done");
      stop_test();
   end
endmodule : tb_pdr_channel_pair
